//--- hw/ccp_pkg.sv
// What this block does
// - pwm time base counts system clocks, so pwm rate follows the clock
// - any reset restores control registers and turns the pin into input
// - duty low bits and mode select reset to zero on every reset
// - control bits 7 and 6 read zero and ignore writes
// - in pwm mode control bits 5:4 are the two duty lsbs
// - duty high byte sits above those two bits forming ten bits
// - mode select 11xx means pwm whatever the low two bits hold
// - mode 1011 on match sets event flag and starts adc if enabled
// - mode 1010 on match only raises the event, pin untouched
// - mode 1001 drives pin low on match and sets event flag
// - mode 1000 drives pin high on match and sets event flag
// - mode 0010 inverts pin on every compare match
// - capture on falling, rising, every 4th or every 16th rising edge
// - mode 0000 switches unit off, capture/compare logic held in reset, period timer keeps running
// - at period end in pwm mode the duty value is copied into the duty shadow
// - pin set at each period restart unless duty is zero
// - pin cleared when ten bit time base equals duty shadow
// - duty shadow byte is read only while pwm mode is active
package ccp_pkg;

   // ======================================================
   // register map, byte addresses on the bus
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_VALUE = 12'h004;
   localparam logic [11:0] OFF_PERIOD = 12'h008;
   localparam logic [11:0] OFF_TIMER_CTRL = 12'h00C;
   localparam logic [11:0] OFF_TIMER_COUNT = 12'h010;
   localparam logic [11:0] OFF_STATUS = 12'h014;
   localparam logic [11:0] OFF_INT_CLEAR = 12'h018;
   localparam logic [11:0] OFF_INT_ENABLE = 12'h01C;

   // ======================================================
   // reset values and bus answers
   localparam logic [7:0] PERIOD_RST = 8'hFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ======================================================
   // mode select codes
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_SWI = 4'hA;
   localparam logic [3:0] MODE_CMP_TRIG = 4'hB;

   // ======================================================
   // carriers
   typedef struct packed {
      logic awvalid;
      logic [11:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [11:0] araddr;
      logic rready;
   } axi_in_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_out_t;

   typedef struct packed {
      logic [1:0] duty_low_bits;
      logic [3:0] unit_mode_select;
   } ctrl_t;

   typedef enum logic [1:0] {
      WR_IDLE = 2'h0,
      WR_ADDR = 2'h1,
      WR_RESP = 2'h3,
      WR_DATA = 2'h2
   } wr_t;

   typedef struct packed {
      axi_out_t bus;
      wr_t wst;
      logic [11:0] wa;
      logic [15:0] wd;
      logic [1:0] ws;
      ctrl_t ctrl;
      logic [15:0] cv;
      logic [1:0] dlatch;
      logic [7:0] period;
      logic t_on;
      logic [7:0] tmr;
      logic [1:0] q;
      logic [15:0] cnt;
      logic pin_prev;
      logic pin_out;
      logic pin_oe_n;
      logic adc_start;
      logic irq;
      logic [1:0] stat;
      logic [1:0] irq_en;
   } unit_state_t;

   typedef struct packed {
      logic [3:0] cnt;
      logic pulse;
   } prescale_state_t;

endpackage : ccp_pkg

//--- hw/edge_prescaler.sv
`timescale 1ns/100ps
module edge_prescaler
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // control
   input wire logic clear,
   input wire logic [1:0] div_sel,
   // edges in, capture out
   input wire logic edge_seen,
   output logic capture_pulse
);

   ccp_pkg::prescale_state_t s_r;
   ccp_pkg::prescale_state_t s_nxt;
   logic [3:0] last;

   // ======================================================
   // edge count that ends a group: 1, 1, 4 or 16 edges
   assign last = (div_sel == 2'h3) ? 4'hF : ((div_sel == 2'h2) ? 4'h3 : 4'h0);

   // count edges, pulse once per group
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.pulse = 1'b0;
      if (clear)
      begin
         s_nxt = '0;
      end
      else if (edge_seen)
      begin
         if (s_r.cnt == last)
         begin
            s_nxt.cnt = 4'h0;
            s_nxt.pulse = 1'b1;
         end
         else
         begin
            s_nxt.cnt = s_r.cnt + 4'h1;
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign capture_pulse = s_r.pulse;

endmodule : edge_prescaler

//--- hw/ccp_unit.sv
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module ccp_unit
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register bus
   input wire ccp_pkg::axi_in_t axi_in,
   output ccp_pkg::axi_out_t axi_out,
   // unit pin
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe_n,
   // converter trigger
   input wire logic adc_enable,
   output logic adc_start,
   // interrupt
   output logic irq
);

   ccp_pkg::unit_state_t s;
   ccp_pkg::unit_state_t n;

   logic [3:0] mode;
   logic pwm_on;
   logic cap_on;
   logic cmp_on;
   logic drive_on;
   logic [9:0] duty;
   logic [9:0] shadow;
   logic [9:0] tbase;
   logic period_end;
   logic match;
   logic edge_seen;
   logic cap_pulse;
   logic aw_hs;
   logic w_hs;

   // ======================================================
   // register decode helpers
   function automatic logic reg_hit(input logic [11:0] a);
      logic hit;
      hit = 1'b0;
      case ({a[11:2], 2'h0})
         ccp_pkg::OFF_CTRL,
         ccp_pkg::OFF_VALUE,
         ccp_pkg::OFF_PERIOD,
         ccp_pkg::OFF_TIMER_CTRL,
         ccp_pkg::OFF_TIMER_COUNT,
         ccp_pkg::OFF_STATUS,
         ccp_pkg::OFF_INT_CLEAR,
         ccp_pkg::OFF_INT_ENABLE: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : reg_hit

   // read view; write-only and unmapped words read zero
   function automatic logic [31:0] rd_word(input ccp_pkg::unit_state_t st,
                                           input logic [11:0] a);
      logic [31:0] v;
      v = 32'h0;
      case ({a[11:2], 2'h0})
         ccp_pkg::OFF_CTRL: v[5:0] = st.ctrl;
         ccp_pkg::OFF_VALUE: v[15:0] = st.cv;
         ccp_pkg::OFF_PERIOD: v[7:0] = st.period;
         ccp_pkg::OFF_TIMER_CTRL: v[0] = st.t_on;
         ccp_pkg::OFF_TIMER_COUNT: v[7:0] = st.tmr;
         ccp_pkg::OFF_STATUS: v[1:0] = st.stat;
         ccp_pkg::OFF_INT_ENABLE: v[1:0] = st.irq_en;
         default: v = 32'h0;
      endcase
      return v;
   endfunction : rd_word

   // ======================================================
   // mode decode
   assign mode = s.ctrl.unit_mode_select;
   assign pwm_on = (mode[3:2] == 2'h3);
   assign cap_on = (mode[3:2] == 2'h1);
   assign cmp_on = (mode == ccp_pkg::MODE_TOGGLE) || (mode[3:2] == 2'h2);
   // reserved codes fall through to off: no drive, no counting
   assign drive_on = pwm_on || (mode == ccp_pkg::MODE_CMP_SET)
                     || (mode == ccp_pkg::MODE_CMP_CLR)
                     || (mode == ccp_pkg::MODE_TOGGLE);

   // ======================================================
   // duty and time base
   assign duty = {s.cv[7:0], s.ctrl.duty_low_bits};
   assign shadow = {s.cv[15:8], s.dlatch};
   // timer count plus the two clock bits, one step per clk
   assign tbase = {s.tmr, s.q};
   assign period_end = s.t_on && (s.q == 2'h3) && (s.tmr == s.period);

   // ======================================================
   // compare match and capture edges
   assign match = cmp_on && (s.cnt == s.cv);
   assign edge_seen = (mode == ccp_pkg::MODE_CAP_FALL)
                      ? (s.pin_prev && !pin_in) : (!s.pin_prev && pin_in);

   // edge grouping, held clear outside capture modes
   edge_prescaler u_prescaler
   (
      .clk(clk),
      .reset_n(reset_n),
      .clear(!cap_on),
      .div_sel(mode[1:0]),
      .edge_seen(edge_seen),
      .capture_pulse(cap_pulse)
   );

   assign aw_hs = axi_in.awvalid && s.bus.awready;
   assign w_hs = axi_in.wvalid && s.bus.wready;

   // ======================================================
   // next state
   always_comb
   begin
      logic do_wr;
      logic [1:0] clr;
      logic [1:0] evt;
      n = s;
      do_wr = 1'b0;
      clr = 2'h0;
      evt = 2'h0;
      n.adc_start = 1'b0;

      // write address and data may arrive in either order
      if (aw_hs)
         n.wa = axi_in.awaddr;
      if (w_hs)
      begin
         n.wd = axi_in.wdata[15:0];
         n.ws = axi_in.wstrb[1:0];
      end
      case (s.wst)
         ccp_pkg::WR_IDLE:
         begin
            if (aw_hs && w_hs)
               do_wr = 1'b1;
            else if (aw_hs)
               n.wst = ccp_pkg::WR_ADDR;
            else if (w_hs)
               n.wst = ccp_pkg::WR_DATA;
         end
         ccp_pkg::WR_ADDR: do_wr = w_hs;
         ccp_pkg::WR_DATA: do_wr = aw_hs;
         ccp_pkg::WR_RESP:
         begin
            if (axi_in.bready)
               n.wst = ccp_pkg::WR_IDLE;
         end
         default: n.wst = ccp_pkg::WR_IDLE;
      endcase

      // register writes, lanes 0 and 1 only
      if (do_wr)
      begin
         n.wst = ccp_pkg::WR_RESP;
         n.bus.bresp = reg_hit(n.wa) ? ccp_pkg::RESP_OKAY : ccp_pkg::RESP_SLVERR;
         case ({n.wa[11:2], 2'h0})
            ccp_pkg::OFF_CTRL:
            begin
               if (n.ws[0])
                  n.ctrl = n.wd[5:0];
            end
            ccp_pkg::OFF_VALUE:
            begin
               if (n.ws[0])
                  n.cv[7:0] = n.wd[7:0];
               if (n.ws[1] && !pwm_on)
                  n.cv[15:8] = n.wd[15:8];
            end
            ccp_pkg::OFF_PERIOD:
            begin
               if (n.ws[0])
                  n.period = n.wd[7:0];
            end
            ccp_pkg::OFF_TIMER_CTRL:
            begin
               if (n.ws[0])
                  n.t_on = n.wd[0];
            end
            ccp_pkg::OFF_INT_CLEAR:
            begin
               if (n.ws[0])
                  clr = n.wd[1:0];
            end
            ccp_pkg::OFF_INT_ENABLE:
            begin
               if (n.ws[0])
                  n.irq_en = n.wd[1:0];
            end
            default: clr = 2'h0;
         endcase
      end
      n.bus.awready = (n.wst == ccp_pkg::WR_IDLE) || (n.wst == ccp_pkg::WR_DATA);
      n.bus.wready = (n.wst == ccp_pkg::WR_IDLE) || (n.wst == ccp_pkg::WR_ADDR);
      n.bus.bvalid = (n.wst == ccp_pkg::WR_RESP);

      // read channel, one read under way at a time
      if (s.bus.rvalid && axi_in.rready)
         n.bus.rvalid = 1'b0;
      if (axi_in.arvalid && s.bus.arready)
      begin
         n.bus.rvalid = 1'b1;
         n.bus.rdata = rd_word(s, axi_in.araddr);
         n.bus.rresp = reg_hit(axi_in.araddr) ? ccp_pkg::RESP_OKAY
                                               : ccp_pkg::RESP_SLVERR;
      end
      n.bus.arready = !n.bus.rvalid;

      // period timer: four clocks per count step
      if (s.t_on)
      begin
         n.q = s.q + 2'h1;
         if (s.q == 2'h3)
            n.tmr = period_end ? 8'h00 : s.tmr + 8'h01;
      end

      // period boundary reloads the duty shadow
      if (period_end)
      begin
         evt[1] = 1'b1;
         if (pwm_on)
         begin
            n.cv[15:8] = s.cv[7:0];
            n.dlatch = s.ctrl.duty_low_bits;
         end
      end

      // pwm edges
      if (pwm_on)
      begin
         if (period_end)
            n.pin_out = (duty != 10'h000);
         else if (s.t_on && (tbase == shadow))
            n.pin_out = 1'b0;
      end

      // compare counter, cleared while not comparing or capturing
      n.cnt = (cmp_on || cap_on) ? s.cnt + 16'h0001 : 16'h0000;
      if (match)
      begin
         evt[0] = 1'b1;
         case (mode)
            ccp_pkg::MODE_CMP_SET: n.pin_out = 1'b1;
            ccp_pkg::MODE_CMP_CLR: n.pin_out = 1'b0;
            ccp_pkg::MODE_TOGGLE: n.pin_out = !s.pin_out;
            ccp_pkg::MODE_CMP_TRIG: n.adc_start = adc_enable;
            default: n.pin_out = s.pin_out;
         endcase
      end

      // capture wins over a software write of the value
      if (cap_pulse && cap_on)
      begin
         n.cv = s.cnt;
         evt[0] = 1'b1;
      end

      // off and reserved modes: pin low and released
      if (!drive_on && !cap_on && !cmp_on)
         n.pin_out = 1'b0;
      n.pin_oe_n = !drive_on;
      n.pin_prev = pin_in;

      // sticky events, a set beats a clear in the same cycle
      n.stat = (s.stat & ~clr) | evt;
      n.irq = |(n.stat & n.irq_en);
   end

   // ======================================================
   // state register; everything returns to reset values
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s <= '0;
         s.pin_oe_n <= 1'b1;
         s.period <= ccp_pkg::PERIOD_RST;
      end
      else
      begin
         s <= n;
      end
   end

   // outputs straight from flops
   assign axi_out = s.bus;
   assign pin_out = s.pin_out;
   assign pin_oe_n = s.pin_oe_n;
   assign adc_start = s.adc_start;
   assign irq = s.irq;

   // ======================================================
   // checks
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_unimpl_zero:
      assert property (axi_in.arvalid && s.bus.arready && axi_in.araddr == ccp_pkg::OFF_CTRL
                       |=> s.bus.rdata[31:6] == 26'h0)
      else $error("control bits above 5 not zero");

   a_duty_latch:
      assert property (pwm_on && period_end |=> shadow == $past(duty))
      else $error("duty shadow not reloaded at period end");

   a_pwm_set:
      assert property (mode[3:2] == 2'h3 && period_end && duty != 10'h000 |=> pin_out)
      else $error("pin not set at period restart");

   a_zero_duty:
      assert property (pwm_on && period_end && duty == 10'h000 |=> !pin_out)
      else $error("pin set with zero duty");

   a_pwm_clear:
      assert property (pwm_on && s.t_on && !period_end && tbase == shadow |=> !pin_out)
      else $error("pin not cleared at duty match");

   a_cmp_high:
      assert property (match && mode == ccp_pkg::MODE_CMP_SET |=> pin_out && s.stat[0])
      else $error("set on match failed");

   a_cmp_low:
      assert property (match && mode == ccp_pkg::MODE_CMP_CLR |=> !pin_out && s.stat[0])
      else $error("clear on match failed");

   a_cmp_toggle:
      assert property (match && mode == ccp_pkg::MODE_TOGGLE |=> pin_out != $past(pin_out))
      else $error("toggle on match failed");

   a_swi_only:
      assert property (match && mode == ccp_pkg::MODE_CMP_SWI |=> $stable(pin_out) && s.stat[0])
      else $error("event-only match moved the pin");

   a_adc_trig:
      assert property (match && mode == ccp_pkg::MODE_CMP_TRIG
                       |=> adc_start == $past(adc_enable) && s.stat[0])
      else $error("trigger match wrong");

   a_off_input:
      assert property (mode == ccp_pkg::MODE_OFF |=> pin_oe_n && !pin_out && s.cnt == 16'h0)
      else $error("off mode not quiet");

   a_shadow_ro:
      assert property (pwm_on && !period_end |=> s.cv[15:8] == $past(s.cv[15:8]))
      else $error("shadow changed during pwm");

   a_capture_take:
      assert property (cap_pulse && cap_on |=> s.cv == $past(s.cnt) && s.stat[0])
      else $error("capture value wrong");

endmodule : ccp_unit

//--- verification/pin_source.sv
`timescale 1ns/100ps
module pin_source
(
   // unit side of the pin
   input wire logic pin_out,
   input wire logic pin_oe_n,
   // level offered by the external source
   input wire logic drive_level,
   // resolved wire level
   output logic pin_level
);
   // ======================================================
   // wire resolution
   // unit level while it drives, otherwise the external source
   assign pin_level = pin_oe_n ? drive_level : pin_out;
endmodule : pin_source

//--- verification/ccp_unit_test.sv
`timescale 1ns/100ps
module ccp_unit_test;
   // ======================================================
   // bench state
   logic clk;
   logic reset_n;
   ccp_pkg::axi_in_t axi_in;
   ccp_pkg::axi_out_t axi_out;
   logic pin_out;
   logic pin_oe_n;
   logic pin_level;
   logic drive_level;
   logic adc_enable;
   logic adc_start;
   logic irq;
   int n_errors;
   int tests_run;
   int adc_cnt;
   int cyc;
   logic [31:0] rd;
   logic [1:0] rs;
   logic [3:0] cmp_mode [5] = '{ccp_pkg::MODE_CMP_SET, ccp_pkg::MODE_CMP_CLR,
      ccp_pkg::MODE_CMP_SWI, ccp_pkg::MODE_CMP_TRIG, ccp_pkg::MODE_TOGGLE};
   logic cmp_pin [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
   logic cmp_oe [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   logic [31:0] cmp_adc [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};

   // ======================================================
   // design and pin source
   ccp_unit ccp_unit_inst (.clk(clk), .reset_n(reset_n), .axi_in(axi_in), .axi_out(axi_out),
      .pin_in(pin_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .adc_enable(adc_enable),
      .adc_start(adc_start), .irq(irq));
   pin_source pin_source_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .drive_level(drive_level), .pin_level(pin_level));

   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // converter pulse count and watchdog
   always @(posedge clk)
   begin
      if (adc_start === 1'b1) adc_cnt++;
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         complete_run();
      end
   end

   // ======================================================
   // shared tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // write: address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      axi_in.awaddr <= a;
      axi_in.wdata <= d;
      axi_in.wstrb <= 4'hF;
      axi_in.awvalid <= 1'b1;
      axi_in.wvalid <= 1'b1;
      axi_in.bready <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (axi_out.bvalid === 1'b1) break;
         if (axi_in.awvalid && axi_out.awready === 1'b1) axi_in.awvalid <= 1'b0;
         if (axi_in.wvalid && axi_out.wready === 1'b1) axi_in.wvalid <= 1'b0;
      end
      axi_in.bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      axi_in.araddr <= a;
      axi_in.arvalid <= 1'b1;
      axi_in.rready <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (axi_out.rvalid === 1'b1)
         begin
            d = axi_out.rdata;
            r = axi_out.rresp;
            break;
         end
         if (axi_in.arvalid && axi_out.arready === 1'b1) axi_in.arvalid <= 1'b0;
      end
      axi_in.rready <= 1'b0;
   endtask : rdr

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string name);
      rdr(a, rd, rs);
      check(name, rd, exp);
   endtask : rchk

   task automatic edges(input int n);
      repeat (n)
      begin
         @(posedge clk);
         drive_level <= 1'b1;
         repeat (4) @(posedge clk);
         drive_level <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : edges

   // high cycles and rising edges of the pin over 64 clocks
   task automatic measure(output int hi, output int rise);
      logic prev;
      hi = 0;
      rise = 0;
      prev = pin_out;
      repeat (64)
      begin
         @(posedge clk);
         if (pin_out === 1'b1) hi++;
         if (pin_out === 1'b1 && prev === 1'b0) rise++;
         prev = pin_out;
      end
   endtask : measure

   // ======================================================
   // scenarios
   task automatic test_regs();
      rchk(ccp_pkg::OFF_CTRL, 32'h0, "ctrl reset");
      rchk(ccp_pkg::OFF_PERIOD, 32'hFF, "period reset");
      wr(ccp_pkg::OFF_CTRL, 32'h000000FF);
      rchk(ccp_pkg::OFF_CTRL, 32'h0000003F, "ctrl top bits");
      wr(ccp_pkg::OFF_CTRL, 32'h0);
      rdr(12'h040, rd, rs);
      check("unmapped resp", rs, ccp_pkg::RESP_SLVERR);
      $display("test regs done");
   endtask : test_regs

   // pwm with the timer stopped clears the counter but keeps the pin level,
   // so a clear-on-match run starts from the high pin left by set-on-match
   task automatic cmp_run(input logic [3:0] m);
      wr(ccp_pkg::OFF_CTRL, 32'h0C);
      wr(ccp_pkg::OFF_VALUE, 32'h20);
      wr(ccp_pkg::OFF_INT_CLEAR, 32'h3);
      adc_cnt = 0;
      wr(ccp_pkg::OFF_CTRL, {28'h0, m});
      repeat (60) @(posedge clk);
   endtask : cmp_run

   task automatic test_compare();
      for (int i = 0; i < 5; i++)
      begin
         cmp_run(cmp_mode[i]);
         check("oe", pin_oe_n, cmp_oe[i]);
         if (!cmp_oe[i]) check("pin", pin_out, cmp_pin[i]);
         check("adc", adc_cnt, cmp_adc[i]);
         rchk(ccp_pkg::OFF_STATUS, 32'h1, "flag");
      end
      adc_enable <= 1'b0;
      cmp_run(ccp_pkg::MODE_CMP_TRIG);
      check("adc off", adc_cnt, 32'h0);
      adc_enable <= 1'b1;
      $display("test compare done");
   endtask : test_compare

   task automatic test_irq();
      wr(ccp_pkg::OFF_INT_ENABLE, 32'h1);
      cmp_run(ccp_pkg::MODE_CMP_SWI);
      check("irq set", irq, 1'b1);
      wr(ccp_pkg::OFF_INT_ENABLE, 32'h0);
      repeat (2) @(posedge clk);
      check("irq mask", irq, 1'b0);
      wr(ccp_pkg::OFF_INT_ENABLE, 32'h1);
      wr(ccp_pkg::OFF_INT_CLEAR, 32'h1);
      repeat (2) @(posedge clk);
      check("irq clear", irq, 1'b0);
      rchk(ccp_pkg::OFF_STATUS, 32'h0, "status clear");
      wr(ccp_pkg::OFF_INT_ENABLE, 32'h0);
      $display("test irq done");
   endtask : test_irq

   // reserved codes are never written by the bench
   task automatic test_capture();
      for (int m = 4; m < 8; m++)
      begin
         wr(ccp_pkg::OFF_CTRL, 32'h0);
         wr(ccp_pkg::OFF_INT_CLEAR, 32'h3);
         wr(ccp_pkg::OFF_CTRL, m);
         edges((m == 7) ? 15 : (m == 6) ? 3 : 0);
         rchk(ccp_pkg::OFF_STATUS, 32'h0, "no capture yet");
         // last edge split: falling mode must ignore the rise
         @(posedge clk);
         drive_level <= 1'b1;
         repeat (4) @(posedge clk);
         rchk(ccp_pkg::OFF_STATUS, (m == 4) ? 32'h0 : 32'h1, "rise");
         drive_level <= 1'b0;
         repeat (4) @(posedge clk);
         rchk(ccp_pkg::OFF_STATUS, 32'h1, "capture");
      end
      $display("test capture done");
   endtask : test_capture

   task automatic test_pwm();
      int h1;
      int h2;
      int r1;
      wr(ccp_pkg::OFF_CTRL, 32'h0);
      wr(ccp_pkg::OFF_PERIOD, 32'h3);
      wr(ccp_pkg::OFF_TIMER_CTRL, 32'h1);
      wr(ccp_pkg::OFF_VALUE, 32'h01);
      wr(ccp_pkg::OFF_CTRL, 32'h2C);
      repeat (64) @(posedge clk);
      measure(h1, r1);
      check("rises", r1, 32'h4);
      check("pwm oe", pin_oe_n, 1'b0);
      wr(ccp_pkg::OFF_VALUE, 32'h02);
      wr(ccp_pkg::OFF_CTRL, 32'h2E);
      repeat (64) @(posedge clk);
      measure(h2, r1);
      check("duty step", h2 - h1, 32'h10);
      wr(ccp_pkg::OFF_VALUE, 32'hAA02);
      rdr(ccp_pkg::OFF_VALUE, rd, rs);
      check("shadow ro", rd[15:8] === 8'hAA, 1'b0);
      wr(ccp_pkg::OFF_VALUE, 32'h0);
      wr(ccp_pkg::OFF_CTRL, 32'h0C);
      repeat (64) @(posedge clk);
      measure(h1, r1);
      check("zero duty", h1, 32'h0);
      wr(ccp_pkg::OFF_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      check("off oe", pin_oe_n, 1'b1);
      $display("test pwm done");
   endtask : test_pwm

   task automatic test_reset();
      wr(ccp_pkg::OFF_CTRL, 32'h38);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      check("reset oe", pin_oe_n, 1'b1);
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rchk(ccp_pkg::OFF_CTRL, 32'h0, "ctrl rereset");
      rchk(ccp_pkg::OFF_PERIOD, 32'hFF, "period rereset");
      $display("test reset done");
   endtask : test_reset

   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   // ======================================================
   // main sequence
   initial
   begin
      reset_n = 1'b0;
      axi_in = '0;
      drive_level = 1'b0;
      adc_enable = 1'b1;
      repeat (12) @(posedge clk);
      check("oe in reset", pin_oe_n, 1'b1);
      reset_n <= 1'b1;
      test_regs();
      test_compare();
      test_irq();
      test_capture();
      test_pwm();
      test_reset();
      complete_run();
   end
endmodule : ccp_unit_test
